// *** src/port_supervisor_map.vh ***
// header: offsets, fields, reset values and timing counts of the port supervisor
// assumes: included by the supervisor design file, 100 MHz system clock
`ifndef PORT_SUPERVISOR_MAP_VH
`define PORT_SUPERVISOR_MAP_VH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define REG_CONTROL       4'h0
`define REG_STATUS        4'h4
`define REG_COMPARATOR    4'h8

// ****************************************************************
// control register fields
// ****************************************************************
`define CTRL_MODE_1_BIT   0
`define CTRL_MODE_2_BIT   1
`define CTRL_MODE_3_BIT   2
`define CTRL_LIMSEL_BIT   3
`define CTRL_ENABLE_BIT   4
`define CTRL_RESET_VALUE  5'h1f

// ****************************************************************
// mode codes {mode_pin_1, mode_pin_2, mode_pin_3, limit_select}
// ****************************************************************
`define MODE_SDP_LOW      4'he
`define MODE_CDP          4'hf
`define MODE_DISCH_0      4'h0
`define MODE_DISCH_1      4'h1
`define MODE_DCP_AUTO_A   4'h2
`define MODE_DCP_AUTO_B   4'h3
`define MODE_DCP_AUTO_C   4'h6
`define MODE_DCP_AUTO_D   4'h7

// ****************************************************************
// timing
// ****************************************************************
`define CLK_FREQ_HZ       100000000
`define ASSERT_TIME_MS    200
`define RELEASE_TIME_MS   3000
`define DISCHARGE_TIME_MS 1
`define ASSERT_CYCLES     (`CLK_FREQ_HZ / 1000 * `ASSERT_TIME_MS)
`define RELEASE_CYCLES    (`CLK_FREQ_HZ / 1000 * `RELEASE_TIME_MS)
`define DISCHARGE_CYCLES  (`CLK_FREQ_HZ / 1000 * `DISCHARGE_TIME_MS)
`define DEGLITCH_CYCLES   16'd800

`endif

// *** src/port_power_status_supervisor.v ***
// holds the supervisory logic of a usb charging port power switch: load status
// qualification, mode handling, current limit select, fault and thermal handling
// assumes: analog sensing arrives as asynchronous comparator levels, classic
// wishbone slave for software, one 100 MHz clock
`timescale 1ns/10ps
`include "port_supervisor_map.vh"

// Behaviour
// - after reset every port advertises charging with the high current limit
// - non-charging mode acts as standard port with the low current limit
// - mode changes happen with or without output discharge depending on pins
// - low limit standard mode to charging mode via limit select never discharges
// - status asserts after load above low limit plus 60 mA for 200 ms
// - in charging downstream mode primary detection asserts status at once
// - status releases after load below low limit plus 10 mA for 3 s
// - status is indication only; charging port keeps the high current limit
// - short present at enable or power up enters constant current directly
// - overload when enabled gives constant current; only thermal limit turns off
// - fault output low during overtemperature or current limit until cleared
// - current limit passes a deglitch before it reaches the fault output
// - overtemperature reaches the fault output with no filtering
// - switch stays off below undervoltage threshold; comparator supplies hysteresis
// - die above 135 C in current limit turns the switch off
// - die above 155 C always turns the switch off
// - switch restarts after cooling about 20 C, cycling until fault clears
// - pins 111 with select 0 low limit standard, select 1 charging downstream
module port_power_status_supervisor #(
  parameter ASSERT_CYCLES    = `ASSERT_CYCLES,
  parameter RELEASE_CYCLES   = `RELEASE_CYCLES,
  parameter DISCHARGE_CYCLES = `DISCHARGE_CYCLES
) (
  input  wire        CLK_SYS,
  input  wire        SYS_RST,
  input  wire        WB_CYC_I,
  input  wire        WB_STB_I,
  input  wire        WB_WE_I,
  input  wire [3:0]  WB_ADR_I,
  input  wire [3:0]  WB_SEL_I,
  input  wire [31:0] WB_DAT_I,
  output reg  [31:0] WB_DAT_O,
  output wire        WB_ACK_O,
  input  wire        LOAD_ABOVE_ASSERT,
  input  wire        LOAD_BELOW_RELEASE,
  input  wire        PRIMARY_DETECT,
  input  wire        CURRENT_LIMIT_ACTIVE,
  input  wire        INPUT_ABOVE_UVLO,
  input  wire        TEMP_ABOVE_135,
  input  wire        TEMP_ABOVE_155,
  input  wire        TEMP_COOLED,
  output reg         SWITCH_ON,
  output reg         HIGH_LIMIT_SELECT,
  output reg         CONSTANT_CURRENT,
  output reg         DISCHARGE_ON,
  output reg         STATUS_N_OE,
  output wire        STATUS_N_O,
  output reg         FAULT_N_OE,
  output wire        FAULT_N_O
);

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  localparam NSYNC = 8;
  wire [NSYNC-1:0] raw_in = {TEMP_COOLED, TEMP_ABOVE_155, TEMP_ABOVE_135, INPUT_ABOVE_UVLO,
                             CURRENT_LIMIT_ACTIVE, PRIMARY_DETECT, LOAD_BELOW_RELEASE,
                             LOAD_ABOVE_ASSERT};
  reg  [NSYNC-1:0] sync_a;
  reg  [NSYNC-1:0] sync_b;
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
      always @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
        end else begin
          sync_a[gi] <= raw_in[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate
  wire load_high   = sync_b[0];
  wire load_low    = sync_b[1];
  wire prim_det    = sync_b[2];
  wire in_limit    = sync_b[3];
  wire uvlo_ok     = sync_b[4];
  wire hot_135     = sync_b[5];
  wire hot_155     = sync_b[6];
  wire cooled      = sync_b[7];

  // ****************************************************************
  // wishbone slave
  // ****************************************************************
  reg  [4:0]  control;
  reg         ack;
  wire        bus_req = WB_CYC_I & WB_STB_I & ~ack;
  assign WB_ACK_O = ack;

  wire [3:0]  mode        = {control[`CTRL_MODE_1_BIT], control[`CTRL_MODE_2_BIT],
                             control[`CTRL_MODE_3_BIT], control[`CTRL_LIMSEL_BIT]};
  wire        enable      = control[`CTRL_ENABLE_BIT];
  reg         thermal_off;
  reg         status_active;
  reg         fault_active;

  always @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      control  <= `CTRL_RESET_VALUE;
      ack      <= 1'b0;
      WB_DAT_O <= 32'h0;
    end else begin
      ack <= bus_req;
      if (bus_req) begin
        WB_DAT_O <= 32'h0;
        if (WB_ADR_I == `REG_CONTROL) begin
          if (WB_WE_I && WB_SEL_I[0])
            control <= WB_DAT_I[4:0];
          WB_DAT_O <= {27'h0, control};
        end else if (WB_ADR_I == `REG_STATUS) begin
          WB_DAT_O <= {26'h0, DISCHARGE_ON, thermal_off, CONSTANT_CURRENT,
                       fault_active, status_active, SWITCH_ON};
        end else if (WB_ADR_I == `REG_COMPARATOR) begin
          WB_DAT_O <= {24'h0, sync_b};
        end
      end
    end
  end

  // ****************************************************************
  // mode decode and discharge on mode change
  // ****************************************************************
  wire mode_cdp     = (mode == `MODE_CDP);
  wire mode_sdp_low = (mode == `MODE_SDP_LOW);
  wire mode_dcp     = (mode == `MODE_DCP_AUTO_A) || (mode == `MODE_DCP_AUTO_B) ||
                      (mode == `MODE_DCP_AUTO_C) || (mode == `MODE_DCP_AUTO_D);
  wire mode_disch   = (mode == `MODE_DISCH_0) || (mode == `MODE_DISCH_1);
  wire detect_mode  = mode_cdp | mode_dcp;

  reg  [3:0]  last_mode;
  reg  [31:0] disch_cnt;
  // 1110 <-> 1111 differs only in the select bit and skips the discharge
  wire pair_swap    = (last_mode[3:1] == 3'h7) && (mode[3:1] == 3'h7);
  wire mode_change  = (mode != last_mode) && !pair_swap;

  always @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      last_mode <= `MODE_CDP;
      disch_cnt <= 32'h0;
    end else begin
      last_mode <= mode;
      if (mode_change)
        disch_cnt <= DISCHARGE_CYCLES;
      else if (disch_cnt != 32'h0)
        disch_cnt <= disch_cnt - 32'h1;
    end
  end

  // ****************************************************************
  // load status qualification
  // ****************************************************************
  reg [31:0] assert_cnt;
  reg [31:0] release_cnt;

  always @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      assert_cnt    <= 32'h0;
      release_cnt   <= 32'h0;
      status_active <= 1'b0;
    end else if (!detect_mode) begin
      assert_cnt    <= 32'h0;
      release_cnt   <= 32'h0;
      status_active <= 1'b0;
    end else if (!status_active) begin
      release_cnt <= 32'h0;
      if (mode_cdp && prim_det) begin
        status_active <= 1'b1;
        assert_cnt    <= 32'h0;
      end else if (!load_high) begin
        assert_cnt <= 32'h0;
      end else if (assert_cnt >= ASSERT_CYCLES - 1) begin
        status_active <= 1'b1;
        assert_cnt    <= 32'h0;
      end else begin
        assert_cnt <= assert_cnt + 32'h1;
      end
    end else begin
      assert_cnt <= 32'h0;
      if (!load_low) begin
        release_cnt <= 32'h0;
      end else if (release_cnt >= RELEASE_CYCLES - 1) begin
        status_active <= 1'b0;
        release_cnt   <= 32'h0;
      end else begin
        release_cnt <= release_cnt + 32'h1;
      end
    end
  end

  // ****************************************************************
  // thermal shutdown with restart
  // ****************************************************************
  always @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      thermal_off <= 1'b0;
    end else if (hot_155 || (hot_135 && in_limit)) begin
      thermal_off <= 1'b1;
    end else if (thermal_off && cooled) begin
      thermal_off <= 1'b0;
    end
  end

  // ****************************************************************
  // current limit deglitch and fault
  // ****************************************************************
  reg [15:0] glitch_cnt;
  reg        limit_fault;

  always @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      glitch_cnt  <= 16'h0;
      limit_fault <= 1'b0;
    end else if (!in_limit) begin
      glitch_cnt  <= 16'h0;
      limit_fault <= 1'b0;
    end else if (glitch_cnt >= `DEGLITCH_CYCLES - 16'd1) begin
      limit_fault <= 1'b1;
    end else begin
      glitch_cnt <= glitch_cnt + 16'h1;
    end
  end

  always @* begin
    fault_active = limit_fault | thermal_off | hot_155;
  end

  // ****************************************************************
  // switch, limit and pin outputs
  // ****************************************************************
  always @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      SWITCH_ON         <= 1'b0;
      HIGH_LIMIT_SELECT <= 1'b1;
      CONSTANT_CURRENT  <= 1'b0;
      DISCHARGE_ON      <= 1'b0;
      STATUS_N_OE       <= 1'b0;
      FAULT_N_OE        <= 1'b0;
    end else begin
      // off in undervoltage, thermal shutdown, discharge, or disabled
      SWITCH_ON <= enable && uvlo_ok && !thermal_off && !mode_disch &&
                   (disch_cnt == 32'h0);
      // low limit only in the standard port modes; status never changes it
      HIGH_LIMIT_SELECT <= !(mode_sdp_low ||
                             (mode[3:1] == 3'h2 && !mode[0]) ||
                             (mode[3:1] == 3'h6 && !mode[0]));
      // short at start or overload: regulate current rather than shut down
      CONSTANT_CURRENT  <= in_limit && enable && uvlo_ok && !thermal_off;
      DISCHARGE_ON      <= mode_disch || (disch_cnt != 32'h0);
      STATUS_N_OE       <= status_active;
      FAULT_N_OE        <= fault_active;
    end
  end

  // open drain: pin only ever pulled low
  assign STATUS_N_O = 1'b0;
  assign FAULT_N_O  = 1'b0;

endmodule // port_power_status_supervisor

// *** tb/port_power_status_supervisor_properties.sv ***
// checker: pin timing relations of the port supervisor
// assumes: bound into the supervisor, counts shortened by parameters
`timescale 1ns/10ps
module port_power_status_supervisor_properties #(
  parameter ASSERT_CYCLES  = 20,
  parameter RELEASE_CYCLES = 50
) (
  input wire logic CLK_SYS, SYS_RST, WB_CYC_I, WB_STB_I, WB_ACK_O,
  input wire logic LOAD_ABOVE_ASSERT, LOAD_BELOW_RELEASE, PRIMARY_DETECT,
  input wire logic CURRENT_LIMIT_ACTIVE, INPUT_ABOVE_UVLO, TEMP_ABOVE_135,
  input wire logic TEMP_ABOVE_155, SWITCH_ON, HIGH_LIMIT_SELECT, STATUS_N_OE,
  input wire logic FAULT_N_OE
);
  logic [15:0] lim_cnt, above_cnt, below_cnt;
  logic [3:0]  hot_age, ack_age;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  // ******************************************
  // run lengths of raw inputs, ages since events
  // ******************************************
  always @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      {lim_cnt, above_cnt, below_cnt, hot_age, ack_age} <= '0;
    end else begin
      lim_cnt   <= CURRENT_LIMIT_ACTIVE ? lim_cnt + 16'h1 : 16'h0;
      above_cnt <= LOAD_ABOVE_ASSERT ? above_cnt + 16'h1 : 16'h0;
      below_cnt <= LOAD_BELOW_RELEASE ? below_cnt + 16'h1 : 16'h0;
      hot_age   <= (TEMP_ABOVE_135 | TEMP_ABOVE_155) ? 4'h0 : hot_age + {3'h0, hot_age != 4'hf};
      ack_age   <= WB_ACK_O ? 4'h0 : ack_age + {3'h0, ack_age != 4'hf};
    end
  end
  sequence bus_req; WB_CYC_I && WB_STB_I && !WB_ACK_O; endsequence
  sequence ack_pulse; WB_ACK_O ##1 !WB_ACK_O; endsequence
  a_bus_answer: assert property (bus_req |=> ack_pulse) else $error("ack not one pulse");
  a_no_stray_ack: assert property ($rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I))
    else $error("ack without request");
  a_reset_state: assert property (disable iff (1'b0) SYS_RST |->
    !SWITCH_ON && HIGH_LIMIT_SELECT && !STATUS_N_OE && !FAULT_N_OE) else $error("reset state");
  a_uvlo_off: assert property (!INPUT_ABOVE_UVLO [*5] |-> !SWITCH_ON)
    else $error("switch on below uvlo");
  a_hot_off: assert property (TEMP_ABOVE_155 [*5] |-> !SWITCH_ON)
    else $error("switch on while hot");
  a_warm_limit_off: assert property ((TEMP_ABOVE_135 && CURRENT_LIMIT_ACTIVE) [*5] |-> !SWITCH_ON)
    else $error("switch on warm in limit");
  a_hot_fault: assert property (TEMP_ABOVE_155 [*4] |-> FAULT_N_OE)
    else $error("late thermal fault");
  a_limit_deglitch: assert property ($rose(FAULT_N_OE) && hot_age > 4'h8 |-> lim_cnt > 16'd795)
    else $error("limit fault too early");
  a_status_qualify: assert property ($rose(STATUS_N_OE) && !$past(PRIMARY_DETECT, 3) &&
    !$past(PRIMARY_DETECT, 4) |-> above_cnt >= ASSERT_CYCLES) else $error("status early");
  a_status_hold: assert property ($fell(STATUS_N_OE) && ack_age > 4'h6 |->
    below_cnt >= RELEASE_CYCLES) else $error("status released early");
  a_limit_kept: assert property (STATUS_N_OE && ack_age > 4'h4 |-> HIGH_LIMIT_SELECT)
    else $error("low limit while status");
endmodule // port_power_status_supervisor_properties
bind port_power_status_supervisor port_power_status_supervisor_properties #(
  .ASSERT_CYCLES(ASSERT_CYCLES), .RELEASE_CYCLES(RELEASE_CYCLES)) i_props (.*);

// *** tb/ppm_controller_model.sv ***
// partner: system power controller watching the status and fault pins
// assumes: both pins open drain with pull-ups, one high power port allowed
`timescale 1ns/10ps
module ppm_controller_model (
  input  wire logic clk, status_oe, status_o, fault_oe, fault_o,
  output logic      status_pin, fault_pin, others_sdp
);
  // released pins float up to the pull-up level
  assign status_pin = status_oe ? status_o : 1'b1;
  assign fault_pin  = fault_oe ? fault_o : 1'b1;
  // other ports go non-charging while this one holds the grant, back on release
  always @(posedge clk) begin
    others_sdp <= !status_pin;
  end
endmodule // ppm_controller_model

// *** tb/port_power_status_supervisor_test.sv ***
// testbench: wishbone and comparator stimulus, register reads checked from a queue
// assumes: design from src/, checker bound in its own file, 100 MHz clock
`timescale 1ns/10ps
module port_power_status_supervisor_test;
  logic CLK_SYS = 0, SYS_RST = 0, WB_CYC_I = 0, WB_STB_I = 0, WB_WE_I = 0;
  logic [3:0] WB_ADR_I = 4'h0, WB_SEL_I = 4'h1;
  logic [31:0] WB_DAT_I = 32'h0, WB_DAT_O, lfsr = 32'h0bcc;
  logic LOAD_ABOVE_ASSERT = 0, LOAD_BELOW_RELEASE = 0, PRIMARY_DETECT = 0, TEMP_COOLED = 0;
  logic CURRENT_LIMIT_ACTIVE = 0, INPUT_ABOVE_UVLO = 0, TEMP_ABOVE_135 = 0, TEMP_ABOVE_155 = 0;
  logic WB_ACK_O, SWITCH_ON, HIGH_LIMIT_SELECT, CONSTANT_CURRENT, DISCHARGE_ON;
  logic STATUS_N_OE, STATUS_N_O, FAULT_N_OE, FAULT_N_O, status_pin, fault_pin, others_sdp;
  logic [31:0] exp_q[$], msk_q[$];
  int bad_count = 0, cmp_count = 0;
  port_power_status_supervisor #(.ASSERT_CYCLES(20), .RELEASE_CYCLES(50),
    .DISCHARGE_CYCLES(10)) i_port_power_status_supervisor (.*);
  ppm_controller_model i_ppm_controller_model (.clk(CLK_SYS), .status_oe(STATUS_N_OE),
    .status_o(STATUS_N_O), .fault_oe(FAULT_N_OE), .fault_o(FAULT_N_O),
    .status_pin(status_pin), .fault_pin(fault_pin), .others_sdp(others_sdp));
  always #5 CLK_SYS = ~CLK_SYS;
  // ******************************************
  // bus cycles and comparisons
  // ******************************************
  task automatic err(input string s);
    bad_count++;
    $display("ERROR %0t %s", $time, s);
  endtask
  task automatic cmp(input logic [31:0] got, exp, msk);
    cmp_count++;
    if ((got & msk) !== (exp & msk)) err($sformatf("got %h exp %h", got, exp));
  endtask
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic hold(input int n);
    repeat (n) @(posedge CLK_SYS);
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_DAT_I} <= {2'b11, w, a, d};
    do begin @(posedge CLK_SYS); n++; end while (WB_ACK_O !== 1'b1 && n < 40);
    if (n >= 40) err("no ack");
    {WB_CYC_I, WB_STB_I} <= 2'b00;
    @(posedge CLK_SYS);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    wb(1'b0, a, 32'h0);
  endtask
  always @(posedge CLK_SYS) begin
    if (WB_ACK_O === 1'b1 && WB_WE_I === 1'b0) begin
      if (exp_q.size() == 0) err("unexpected read");
      else cmp(WB_DAT_O, exp_q.pop_front(), msk_q.pop_front());
    end
  end
  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    hold(30000);
    err("timeout");
    finish_test;
  end
  // ******************************************
  // scenarios
  // ******************************************
  initial begin
    SYS_RST <= 1;
    hold(16);
    SYS_RST <= 0;
    rd(4'h0, 32'h1f, 32'h1f);
    rd(4'h4, 32'h0, 32'h3);
    rd(4'hc, 32'h0, 32'hffffffff);
    cmp({31'h0, HIGH_LIMIT_SELECT}, 32'h1, 32'h1);
    INPUT_ABOVE_UVLO <= 1;
    hold(6);
    rd(4'h4, 32'h1, 32'h1);
    repeat (3) begin
      lfsr = lfsr_next(lfsr);
      LOAD_ABOVE_ASSERT <= 1;
      hold(int'(lfsr % 14) + 5);
      LOAD_ABOVE_ASSERT <= 0;
      hold(1);
    end
    rd(4'h4, 32'h0, 32'h2);
    LOAD_ABOVE_ASSERT <= 1;
    hold(26);
    rd(4'h4, 32'h2, 32'h2);
    cmp({31'h0, status_pin}, 32'h0, 32'h1);
    cmp({31'h0, others_sdp}, 32'h1, 32'h1);
    cmp({31'h0, HIGH_LIMIT_SELECT}, 32'h1, 32'h1);
    {LOAD_ABOVE_ASSERT, LOAD_BELOW_RELEASE} <= 2'b01;
    hold(40);
    LOAD_BELOW_RELEASE <= 0;
    hold(1);
    LOAD_BELOW_RELEASE <= 1;
    hold(40);
    rd(4'h4, 32'h2, 32'h2);
    hold(20);
    rd(4'h4, 32'h0, 32'h2);
    cmp({31'h0, others_sdp}, 32'h0, 32'h1);
    {PRIMARY_DETECT, LOAD_BELOW_RELEASE} <= 2'b10;
    hold(5);
    rd(4'h4, 32'h2, 32'h2);
    PRIMARY_DETECT <= 0;
    wb(1'b1, 4'h0, 32'h17);
    rd(4'h4, 32'h1, 32'h23);
    cmp({31'h0, HIGH_LIMIT_SELECT}, 32'h0, 32'h1);
    wb(1'b1, 4'h0, 32'h1f);
    rd(4'h4, 32'h1, 32'h21);
    cmp({31'h0, HIGH_LIMIT_SELECT}, 32'h1, 32'h1);
    wb(1'b1, 4'h0, 32'h1c);
    rd(4'h4, 32'h20, 32'h21);
    hold(16);
    LOAD_ABOVE_ASSERT <= 1;
    hold(26);
    rd(4'h4, 32'h3, 32'h23);
    {LOAD_ABOVE_ASSERT, CURRENT_LIMIT_ACTIVE} <= 2'b01;
    hold(700);
    rd(4'h4, 32'h9, 32'hd);
    hold(120);
    rd(4'h4, 32'hd, 32'hd);
    cmp({31'h0, fault_pin}, 32'h0, 32'h1);
    CURRENT_LIMIT_ACTIVE <= 0;
    hold(4);
    rd(4'h4, 32'h1, 32'hd);
    {CURRENT_LIMIT_ACTIVE, TEMP_ABOVE_135} <= 2'b11;
    hold(6);
    rd(4'h4, 32'h14, 32'h15);
    TEMP_ABOVE_135 <= 0;
    hold(6);
    rd(4'h4, 32'h10, 32'h11);
    TEMP_COOLED <= 1;
    hold(6);
    rd(4'h4, 32'h1, 32'h11);
    {CURRENT_LIMIT_ACTIVE, TEMP_COOLED, TEMP_ABOVE_155} <= 3'b001;
    hold(6);
    rd(4'h4, 32'h14, 32'h15);
    {TEMP_COOLED, TEMP_ABOVE_155} <= 2'b10;
    hold(6);
    rd(4'h4, 32'h1, 32'h15);
    wb(1'b1, 4'h0, 32'h0f);
    CURRENT_LIMIT_ACTIVE <= 1;
    hold(4);
    wb(1'b1, 4'h0, 32'h1f);
    hold(4);
    rd(4'h4, 32'h8, 32'h8);
    {CURRENT_LIMIT_ACTIVE, INPUT_ABOVE_UVLO} <= 2'b00;
    hold(6);
    rd(4'h4, 32'h0, 32'h1);
    finish_test;
  end
endmodule // port_power_status_supervisor_test
